/* common/ptm_map.vh */
`ifndef PTM_MAP_VH
`define PTM_MAP_VH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PTM_IDX_CNT_EVEN_A 10'h106
`define PTM_IDX_HOLD_A 10'h108
`define PTM_IDX_CNT_ODD_A 10'h10A
`define PTM_IDX_PER_EVEN_A 10'h10C
`define PTM_IDX_PER_ODD_A 10'h10E
`define PTM_IDX_CTRL_EVEN_A 10'h110
`define PTM_IDX_CTRL_ODD_A 10'h112
`define PTM_IDX_CNT_EVEN_B 10'h114
`define PTM_IDX_HOLD_B 10'h116
`define PTM_IDX_CNT_ODD_B 10'h118
`define PTM_IDX_PER_EVEN_B 10'h11A
`define PTM_IDX_PER_ODD_B 10'h11C
`define PTM_IDX_CTRL_EVEN_B 10'h11E
`define PTM_IDX_CTRL_ODD_B 10'h120
`define PTM_IDX_INT_STATUS 10'h130
`define PTM_IDX_INT_MASK 10'h132
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PTM_CTL_ON 15
`define PTM_CTL_STOP_IDLE 13
`define PTM_CTL_GATE 6
`define PTM_CTL_PS_HI 5
`define PTM_CTL_PS_LO 4
`define PTM_CTL_JOIN 3
`define PTM_CTL_EXT 1
`define PTM_CTL_WMASK_EVEN 16'hA07A
`define PTM_CTL_WMASK_ODD 16'hA072
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PTM_RST_CTL 16'h0000
`define PTM_RST_CNT 16'h0000
`define PTM_RST_PER 16'hFFFF
`define PTM_RST_HOLD 16'h0000
`define PTM_RST_INT 4'h0
// ----------------------------------------------------------------
// Prescaler terminal counts (ratio minus one)
// ----------------------------------------------------------------
`define PTM_PS_LIM_1 8'h00
`define PTM_PS_LIM_8 8'h07
`define PTM_PS_LIM_64 8'h3F
`define PTM_PS_LIM_256 8'hFF
`endif

/* hw/ptm_sync2.v */
`timescale 1ns/1ns
// Two-stage synchroniser for pin levels
module ptm_sync2 #(
  parameter W = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Levels
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;

  // First stage is read only by the second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // ptm_sync2

/* hw/ptm_tick.v */
`timescale 1ns/1ns
`include "ptm_map.vh"
// Clock source select, gate qualifier and prescaler of one timer
module ptm_tick (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Setup
  input wire run,
  input wire ext_sel,
  input wire gate_en,
  input wire [1:0] ps_sel,
  // Synchronised pin events
  input wire ext_rise,
  input wire gate_lvl,
  // Prescaled counting edge
  output reg tick
);
  reg [7:0] pre_reg;
  reg [7:0] lim;
  reg src;

  // Source and terminal count
  always @* begin
    case (ps_sel)
      2'b00: lim = `PTM_PS_LIM_1;
      2'b01: lim = `PTM_PS_LIM_8;
      2'b10: lim = `PTM_PS_LIM_64;
      default: lim = `PTM_PS_LIM_256;
    endcase
    if (ext_sel) begin
      src = ext_rise; // external events, already synchronised
    end else if (gate_en) begin
      src = gate_lvl; // accumulate only while gate is high
    end else begin
      src = 1'b1;
    end
  end

  // Prescaler; cleared while stopped so a restart begins clean
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      pre_reg <= 8'h00;
      tick <= 1'b0;
    end else if (src) begin
      if (pre_reg >= lim) begin // selectable prescaler
        pre_reg <= 8'h00;
        tick <= 1'b1;
      end else begin
        pre_reg <= pre_reg + 8'h01;
        tick <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // ptm_tick

/* hw/ptm_top.v */
// Notes on behaviour
// - Each pair runs as one 32-bit timer or as two 16-bit timers.
// - Split timers support every 16-bit mode but asynchronous counting.
// - A joined pair can count synchronised external events in 32 bits.
// - Gating, a prescaler, and running on in idle and sleep are offered.
// - A joined pair interrupts when its count matches its 32-bit period.
// - Only pair a's two counts are offered as capture/compare time base.
// - Converter trigger comes from a joined pair or the odd timer only.
// - Every 16-bit timer can be a synchronous timer or counter.
// - Joined: even timer is the low word, odd timer the high word.
// - Joined: the odd control register is ignored, even one rules.
// - Joined: the even timer's clock and gate inputs drive the count.
// - Joined: period match raises the odd timer's flag, not the even.
// - All four timers can request a DMA transfer.
// - Each pair has a high-word holding register for 32-bit use.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "ptm_map.vh"
module ptm_top #(
  parameter AW = 12
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire [AW-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Timer pins: index 0 even a, 1 odd a, 2 even b, 3 odd b
  input wire [3:0] ext_clk_pin,
  input wire [3:0] gate_pin,
  // Power state
  input wire idle_mode,
  // Events out
  output reg irq,
  output reg conv_trig_a,
  output reg conv_trig_b,
  output reg [3:0] dma_req,
  // Time base for capture and compare units
  output wire [15:0] tb_count_even_a,
  output wire [15:0] tb_count_odd_a
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [15:0] cnt_reg [0:3];
  reg [15:0] per_reg [0:3];
  reg [15:0] ctl_reg [0:3];
  reg [15:0] hold_reg [0:1];
  reg [3:0] int_status_reg;
  reg [3:0] int_mask_reg;
  reg [3:0] evt_reg;
  reg [3:0] ext_prev_reg;
  wire [7:0] pin_sync;
  wire [3:0] ext_rise;
  wire [3:0] tick;
  reg [3:0] run;
  reg [1:0] pair_join;
  reg [3:0] m16;
  reg [1:0] m32;
  reg [3:0] evt;
  reg [31:0] rd_data;
  reg rd_hit;
  wire [9:0] idx;
  wire acc;
  wire acc_wr;
  wire setup_rd;
  integer i;
  integer p;
  integer ri;
  integer mi;
  integer mp;

  // ----------------------------------------------------------------
  // Index of each timer's registers
  // ----------------------------------------------------------------
  function [9:0] cnt_idx;
    input integer n;
    begin
      case (n)
        0: cnt_idx = `PTM_IDX_CNT_EVEN_A;
        1: cnt_idx = `PTM_IDX_CNT_ODD_A;
        2: cnt_idx = `PTM_IDX_CNT_EVEN_B;
        default: cnt_idx = `PTM_IDX_CNT_ODD_B;
      endcase
    end
  endfunction

  function [9:0] per_idx;
    input integer n;
    begin
      case (n)
        0: per_idx = `PTM_IDX_PER_EVEN_A;
        1: per_idx = `PTM_IDX_PER_ODD_A;
        2: per_idx = `PTM_IDX_PER_EVEN_B;
        default: per_idx = `PTM_IDX_PER_ODD_B;
      endcase
    end
  endfunction

  function [9:0] ctl_idx;
    input integer n;
    begin
      case (n)
        0: ctl_idx = `PTM_IDX_CTRL_EVEN_A;
        1: ctl_idx = `PTM_IDX_CTRL_ODD_A;
        2: ctl_idx = `PTM_IDX_CTRL_EVEN_B;
        default: ctl_idx = `PTM_IDX_CTRL_ODD_B;
      endcase
    end
  endfunction

  function [9:0] hold_idx;
    input integer n;
    begin
      if (n == 0) begin
        hold_idx = `PTM_IDX_HOLD_A;
      end else begin
        hold_idx = `PTM_IDX_HOLD_B;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // No wait state: pready rises in the access phase
  assign idx = paddr[11:2];
  assign acc = psel & penable & pready;
  assign acc_wr = acc & pwrite & rd_hit;
  assign setup_rd = psel & ~penable & ~pwrite;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  ptm_sync2 #(
    .W(8)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({gate_pin, ext_clk_pin}),
    .sync_out(pin_sync)
  );

  // Edge detector looks only at the second synchroniser stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_reg <= 4'h0;
    end else begin
      ext_prev_reg <= pin_sync[3:0];
    end
  end
  assign ext_rise = pin_sync[3:0] & ~ext_prev_reg;

  // ----------------------------------------------------------------
  // Run enables, one prescaler per timer
  // ----------------------------------------------------------------
  // No sleep input: pclk logic keeps counting through sleep
  always @* begin
    pair_join[0] = ctl_reg[0][`PTM_CTL_JOIN];
    pair_join[1] = ctl_reg[2][`PTM_CTL_JOIN];
    for (ri = 0; ri < 4; ri = ri + 1) begin
      run[ri] = ctl_reg[ri][`PTM_CTL_ON] &
        ~(ctl_reg[ri][`PTM_CTL_STOP_IDLE] & idle_mode);
    end
    run[1] = run[1] & ~pair_join[0]; // odd setup ignored
    run[3] = run[3] & ~pair_join[1];
  end

  // Each instance takes its own pins, so a joined pair uses even pins
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tick
      ptm_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(run[g]),
        .ext_sel(ctl_reg[g][`PTM_CTL_EXT]),
        .gate_en(ctl_reg[g][`PTM_CTL_GATE]),
        .ps_sel(ctl_reg[g][`PTM_CTL_PS_HI:`PTM_CTL_PS_LO]),
        .ext_rise(ext_rise[g]),
        .gate_lvl(pin_sync[4+g]),
        .tick(tick[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Period matches and per-timer events
  // ----------------------------------------------------------------
  always @* begin
    for (mi = 0; mi < 4; mi = mi + 1) begin
      m16[mi] = tick[mi] & (cnt_reg[mi] == per_reg[mi]);
    end
    for (mp = 0; mp < 2; mp = mp + 1) begin
      m32[mp] = tick[2*mp] & pair_join[mp] &
        ({cnt_reg[2*mp+1], cnt_reg[2*mp]} ==
         {per_reg[2*mp+1], per_reg[2*mp]});
      evt[2*mp] = m16[2*mp] & ~pair_join[mp];
      evt[2*mp+1] = pair_join[mp] ? m32[mp] : m16[2*mp+1];
    end
  end

  // ----------------------------------------------------------------
  // Counters, periods, controls, holding registers
  // ----------------------------------------------------------------
  // Bus writes win over a counting edge in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        cnt_reg[i] <= `PTM_RST_CNT;
        per_reg[i] <= `PTM_RST_PER;
        ctl_reg[i] <= `PTM_RST_CTL;
      end
      hold_reg[0] <= `PTM_RST_HOLD;
      hold_reg[1] <= `PTM_RST_HOLD;
    end else begin
      for (p = 0; p < 2; p = p + 1) begin
        if (pair_join[p]) begin
          // Low word in the even timer, high in the odd
          if (m32[p]) begin
            cnt_reg[2*p] <= 16'h0000;
            cnt_reg[2*p+1] <= 16'h0000;
          end else if (tick[2*p]) begin
            cnt_reg[2*p] <= cnt_reg[2*p] + 16'h0001;
            if (cnt_reg[2*p] == 16'hFFFF) begin
              cnt_reg[2*p+1] <= cnt_reg[2*p+1] + 16'h0001;
            end
          end
        end else begin
          // Two independent synchronous timers
          for (i = 2*p; i < 2*p+2; i = i + 1) begin
            if (m16[i]) begin
              cnt_reg[i] <= 16'h0000;
            end else if (tick[i]) begin
              cnt_reg[i] <= cnt_reg[i] + 16'h0001;
            end
          end
        end
        // Snapshot on the setup edge, the edge prdata samples the low word
        if (setup_rd && pair_join[p] && idx == cnt_idx(2*p)) begin
          hold_reg[p] <= cnt_reg[2*p+1];
        end
        if (acc_wr && idx == hold_idx(p)) begin
          hold_reg[p] <= pwdata[15:0];
        end
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (acc_wr && idx == cnt_idx(i)) begin
          cnt_reg[i] <= pwdata[15:0];
          // Low-word write in 32-bit use loads high word from hold
          if (i % 2 == 0 && pair_join[i/2]) begin
            cnt_reg[i+1] <= hold_reg[i/2];
          end
        end
        if (acc_wr && idx == per_idx(i)) begin
          per_reg[i] <= pwdata[15:0];
        end
        if (acc_wr && idx == ctl_idx(i)) begin
          ctl_reg[i] <= pwdata[15:0] & ((i % 2 == 0) ?
            `PTM_CTL_WMASK_EVEN : `PTM_CTL_WMASK_ODD);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------
  // Registered one cycle after the match so every output is a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= 4'h0;
      dma_req <= 4'h0;
      conv_trig_a <= 1'b0;
      conv_trig_b <= 1'b0;
    end else begin
      evt_reg <= evt;
      dma_req <= evt; // all four timers may start DMA
      conv_trig_a <= evt[1]; // odd flag covers joined and split
      conv_trig_b <= evt[3];
    end
  end

  // Only pair a feeds capture and compare
  assign tb_count_even_a = cnt_reg[0];
  assign tb_count_odd_a = cnt_reg[1];

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // A new event wins over a write-one-to-clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= `PTM_RST_INT;
      int_mask_reg <= `PTM_RST_INT;
      irq <= 1'b0;
    end else begin
      if (acc_wr && idx == `PTM_IDX_INT_STATUS) begin
        int_status_reg <= (int_status_reg & ~pwdata[3:0]) | evt_reg;
      end else begin
        int_status_reg <= int_status_reg | evt_reg;
      end
      if (acc_wr && idx == `PTM_IDX_INT_MASK) begin
        int_mask_reg <= pwdata[3:0];
      end
      irq <= |(int_status_reg & int_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (idx)
      `PTM_IDX_CNT_EVEN_A: rd_data[15:0] = cnt_reg[0];
      `PTM_IDX_CNT_ODD_A: rd_data[15:0] = cnt_reg[1];
      `PTM_IDX_CNT_EVEN_B: rd_data[15:0] = cnt_reg[2];
      `PTM_IDX_CNT_ODD_B: rd_data[15:0] = cnt_reg[3];
      `PTM_IDX_PER_EVEN_A: rd_data[15:0] = per_reg[0];
      `PTM_IDX_PER_ODD_A: rd_data[15:0] = per_reg[1];
      `PTM_IDX_PER_EVEN_B: rd_data[15:0] = per_reg[2];
      `PTM_IDX_PER_ODD_B: rd_data[15:0] = per_reg[3];
      `PTM_IDX_CTRL_EVEN_A: rd_data[15:0] = ctl_reg[0];
      `PTM_IDX_CTRL_ODD_A: rd_data[15:0] = ctl_reg[1];
      `PTM_IDX_CTRL_EVEN_B: rd_data[15:0] = ctl_reg[2];
      `PTM_IDX_CTRL_ODD_B: rd_data[15:0] = ctl_reg[3];
      `PTM_IDX_HOLD_A: rd_data[15:0] = hold_reg[0];
      `PTM_IDX_HOLD_B: rd_data[15:0] = hold_reg[1];
      `PTM_IDX_INT_STATUS: rd_data[3:0] = int_status_reg;
      `PTM_IDX_INT_MASK: rd_data[3:0] = int_mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // Data captured in setup; a counter may move by the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= ~rd_hit;
      prdata <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // ptm_top

/* test/ptm_checker_properties.sv */
`timescale 1ns/1ns
`include "ptm_map.vh"
// ----------------------------------------------------------------
// Port checker of the paired timer block
// ----------------------------------------------------------------
module ptm_checker_props #(
  parameter AW = 12
) (
  // Bus side
  input wire pclk,
  input wire presetn,
  input wire [AW-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Events
  input wire irq,
  input wire conv_trig_a,
  input wire conv_trig_b,
  input wire [3:0] dma_req,
  input wire [15:0] tb_count_even_a
);
  wire setup;
  wire hit;
  // Decode of the register window; aligned accesses only are judged
  assign setup = psel && !penable && (paddr[1:0] == 2'b00);
  assign hit = (paddr[11:2] >= `PTM_IDX_CNT_EVEN_A &&
    paddr[11:2] <= `PTM_IDX_CTRL_ODD_B && !paddr[2]) ||
    paddr[11:2] == `PTM_IDX_INT_STATUS ||
    paddr[11:2] == `PTM_IDX_INT_MASK;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_unmapped: assert property (setup && !hit |=> pslverr && pready)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && hit |=> !pslverr)
    else $error("mapped access refused");
  a_err_data_zero: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returns data");
  a_trig_a_odd: assert property (conv_trig_a |-> dma_req[1])
    else $error("pair a trigger without odd event");
  a_trig_b_odd: assert property (conv_trig_b |-> dma_req[3])
    else $error("pair b trigger without odd event");
  a_reset_quiet: assert property ($rose(presetn) |->
    !irq && dma_req == 4'h0 && tb_count_even_a == 16'h0000)
    else $error("outputs not quiet after reset");
endmodule // ptm_checker_props

bind ptm_top ptm_checker_props #(.AW(AW)) u_chk (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .conv_trig_a(conv_trig_a), .conv_trig_b(conv_trig_b),
  .dma_req(dma_req), .tb_count_even_a(tb_count_even_a));

/* test/ptm_far_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Converter and DMA side: request counters and timer pin drivers
// ----------------------------------------------------------------
module ptm_far_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Requests from the timers
  input wire [3:0] dma_req,
  input wire conv_trig_a,
  input wire conv_trig_b,
  // Pins toward the timers
  output logic [3:0] ext_clk_pin,
  output logic [3:0] gate_pin
);
  int ev_cnt [0:5];
  initial begin
    ext_clk_pin = 4'h0;
    gate_pin = 4'h0;
  end
  // Each request is one cycle, so one count per high cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 6; i++) ev_cnt[i] <= 0;
    end else begin
      for (int i = 0; i < 4; i++) ev_cnt[i] <= ev_cnt[i] + dma_req[i];
      ev_cnt[4] <= ev_cnt[4] + conv_trig_a;
      ev_cnt[5] <= ev_cnt[5] + conv_trig_b;
    end
  end
  // Gate levels change just after a rising edge
  task automatic set_gate(input logic [3:0] m);
    gate_pin <= m;
  endtask
  // Slow pin pulses so the two-stage synchroniser sees every edge
  task automatic pulse_ext(input logic [3:0] m, input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      ext_clk_pin <= ext_clk_pin | m;
      repeat (4) @(posedge pclk);
      ext_clk_pin <= ext_clk_pin & ~m;
    end
  endtask
endmodule // ptm_far_model

/* test/tb_paired_timer_32bit.sv */
`timescale 1ns/1ns
`include "ptm_map.vh"
module tb_paired_timer_32bit;
  logic pclk;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic idle_mode = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, irq, conv_trig_a, conv_trig_b;
  wire [3:0] dma_req, ext_clk_pin, gate_pin;
  wire [15:0] tb_count_even_a, tb_count_odd_a;
  int fails = 0;
  int num_checks = 0;
  int t, c0;
  int ratio [0:3] = '{1, 8, 64, 256};
  logic [31:0] r;
  logic e;
  ptm_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin),
    .idle_mode(idle_mode), .irq(irq), .conv_trig_a(conv_trig_a),
    .conv_trig_b(conv_trig_b), .dma_req(dma_req),
    .tb_count_even_a(tb_count_even_a), .tb_count_odd_a(tb_count_odd_a));
  ptm_far_model u_far (.pclk(pclk), .presetn(presetn),
    .dma_req(dma_req), .conv_trig_a(conv_trig_a),
    .conv_trig_b(conv_trig_b), .ext_clk_pin(ext_clk_pin),
    .gate_pin(gate_pin));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
      fails++;
    end
  endtask
  // Holds the request until pready is seen; idle cycle after it
  task automatic apb(input logic w, input [9:0] i, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h0000_0001, {31'h0, pready});
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input [9:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rd(input string nm, input [9:0] i, input logic [31:0] x);
    apb(1'b0, i, 32'h0000_0000);
    chk(nm, x, r);
  endtask
  // Cycles up to the next request pulse of timer i
  task automatic gap(input int i);
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (dma_req[i] !== 1'b1 && t < 2000);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // The longest test needs some 2000 cycles
  initial begin
    #80000;
    chk("watchdog", 32'h0000_0000, 32'h0000_0001);
    tally_and_finish;
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("per_even_a", `PTM_IDX_PER_EVEN_A, 32'h0000_FFFF);
    rd("hold_a", `PTM_IDX_HOLD_A, 32'h0000_0000);
    rd("ctrl_odd_b", `PTM_IDX_CTRL_ODD_B, 32'h0000_0000);
    apb(1'b0, 10'h000, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, e});
    chk("err_rdata", 32'h0000_0000, r);
    // Split even timer: spacing of matches for every prescale ratio
    wr(`PTM_IDX_PER_EVEN_A, 32'h0000_0002);
    wr(`PTM_IDX_INT_MASK, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      wr(`PTM_IDX_CTRL_EVEN_A, 32'h0000_8000 | (k << 4));
      gap(0);
      gap(0);
      chk("gap_even_a", 3 * ratio[k], t);
    end
    chk("irq_on", 32'h0000_0001, {31'h0, irq});
    wr(`PTM_IDX_CTRL_EVEN_A, 32'h0000_0000);
    wr(`PTM_IDX_INT_MASK, 32'h0000_0000);
    @(posedge pclk);
    chk("irq_masked", 32'h0000_0000, {31'h0, irq});
    rd("status_a", `PTM_IDX_INT_STATUS, 32'h0000_0001);
    wr(`PTM_IDX_INT_STATUS, 32'h0000_0001);
    rd("status_clr", `PTM_IDX_INT_STATUS, 32'h0000_0000);
    chk("trig_even", 32'h0000_0000, u_far.ev_cnt[4]);
    // Split odd timer drives the converter trigger
    wr(`PTM_IDX_PER_ODD_A, 32'h0000_0003);
    wr(`PTM_IDX_CTRL_ODD_A, 32'h0000_8000);
    gap(1);
    gap(1);
    chk("gap_odd_a", 32'h0000_0004, t);
    wr(`PTM_IDX_CTRL_ODD_A, 32'h0000_0000);
    chk("trig_odd", u_far.ev_cnt[1], u_far.ev_cnt[4]);
    // Joined pair a; odd control holds a slow ratio that must be ignored
    wr(`PTM_IDX_CTRL_EVEN_A, 32'h0000_0008);
    wr(`PTM_IDX_CTRL_ODD_A, 32'h0000_8030);
    wr(`PTM_IDX_PER_EVEN_A, 32'h0000_0000);
    wr(`PTM_IDX_PER_ODD_A, 32'h0000_0002);
    wr(`PTM_IDX_HOLD_A, 32'h0000_0001);
    wr(`PTM_IDX_CNT_EVEN_A, 32'h0000_FFFE);
    chk("odd_load", 32'h0000_0001, tb_count_odd_a);
    rd("low_a", `PTM_IDX_CNT_EVEN_A, 32'h0000_FFFE);
    rd("hold_rd", `PTM_IDX_HOLD_A, 32'h0000_0001);
    wr(`PTM_IDX_INT_STATUS, 32'h0000_000F);
    c0 = u_far.ev_cnt[0];
    wr(`PTM_IDX_CTRL_EVEN_A, 32'h0000_8008);
    t = 0;
    while (tb_count_odd_a !== 16'h0002 && t < 50) begin
      @(posedge pclk);
      t++;
    end
    chk("carry_time", 32'h0000_0001, t < 50);
    chk("carry_low", 32'h0000_0000, tb_count_even_a);
    gap(1);
    chk("join_match", 32'h0000_0001, t < 4);
    rd("status_join", `PTM_IDX_INT_STATUS, 32'h0000_0002);
    chk("even_quiet", c0, u_far.ev_cnt[0]);
    wr(`PTM_IDX_CTRL_EVEN_A, 32'h0000_0000);
    // Pair b: gating, stop in idle, joined external counting
    wr(`PTM_IDX_CTRL_EVEN_B, 32'h0000_8040);
    repeat (20) @(posedge pclk);
    rd("gate_low", `PTM_IDX_CNT_EVEN_B, 32'h0000_0000);
    u_far.set_gate(4'h4);
    repeat (20) @(posedge pclk);
    apb(1'b0, `PTM_IDX_CNT_EVEN_B, 32'h0000_0000);
    chk("gate_high", 32'h0000_0001, r != 0);
    wr(`PTM_IDX_CTRL_EVEN_B, 32'h0000_0000);
    wr(`PTM_IDX_CNT_EVEN_B, 32'h0000_0000);
    idle_mode <= 1'b1;
    wr(`PTM_IDX_CTRL_EVEN_B, 32'h0000_A000);
    repeat (10) @(posedge pclk);
    rd("idle_stop", `PTM_IDX_CNT_EVEN_B, 32'h0000_0000);
    wr(`PTM_IDX_CTRL_EVEN_B, 32'h0000_000A);
    idle_mode <= 1'b0;
    wr(`PTM_IDX_PER_EVEN_B, 32'h0000_0003);
    wr(`PTM_IDX_PER_ODD_B, 32'h0000_0000);
    wr(`PTM_IDX_CTRL_EVEN_B, 32'h0000_800A);
    c0 = u_far.ev_cnt[3];
    u_far.pulse_ext(4'h4, 4);
    repeat (10) @(posedge pclk);
    chk("ext_events", c0 + 1, u_far.ev_cnt[3]);
    chk("trig_b", 32'h0000_0001, u_far.ev_cnt[5]);
    rd("ext_low", `PTM_IDX_CNT_EVEN_B, 32'h0000_0000);
    tally_and_finish;
  end
endmodule // tb_paired_timer_32bit
